/* File: logic/rcc_top.sv */
// Overview of operation
// [R1] One 8-bit config register per channel, readable and writable always.
// [R2] Software changes a channel's register only while no request is loaded.
// [R3] Reset leaves both config registers unchanged; no defined reset value.
// [R4] Check-sequence-disable bit holds the suppress signal for the whole request.
// [R5] Returning-frame CHECK_SEQUENCE_DISABLE_BIT requirement depends only on the valid-CHECK_SEQUENCE_DISABLE_BIT bit.
// [R6] Void-strip bit holds the void-strip output for the whole request.
// [R7] Output-select bit may route void-strip onto the ring transparency input.
// [R8] Transparency bit drives source-address-ignore, optionally the transparency input.
// [R9] With transparency set, full confirmation uses the external match signal.
// [R10] Frame control transparency takes FC from the data unit.
// [R11] Confirmation compares all FC bits, or only class/length/reserved bits.
// [R12] Descriptor FC decode drives claim and beacon request outputs.
// [R13] Beacon/claim descriptor with transparency allows any frame type.
// [R14] Hold set: service opportunity not ended before request completes.
// [R15] Hold clear: end when idle, non-immediate, FIFO empty, nothing fetched.
// [R16] Hold clear: channel 1 prestages regardless, except immediate classes.
// [R17] Hold set: channel 1 prestaging follows the preempt/prestage bit.
// [R18] Hold clear on repeat: check other channel before token release.
// [R19] Software sets hold for small repeated frames or guaranteed service.
// [R20] Preempt/prestage bit: channel 0 preempts, channel 1 prestages.
// [R21] Threshold field with extended bit selects FIFO fill before transmit.
//
// Local design decision: register access over APB.
`default_nettype none
module rcc_top (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic PREADY_OUT,
    output logic [31:0] PRDATA_OUT,
    output logic PSLVERR_OUT,
    input wire logic ACTIVE_CH_IN,
    input wire logic [1:0] REQ_LOADED_IN,
    input wire logic [1:0] REQ_FETCHED_IN,
    input wire logic [1:0] IMMEDIATE_IN,
    input wire logic [1:0] REPEAT_IN,
    input wire logic FIFO_EMPTY_IN,
    input wire logic [7:0] DESC_FC_IN,
    input wire logic [7:0] ODU_FC_IN,
    input wire logic [7:0] RET_FC_IN,
    input wire logic FULL_CONF_IN,
    input wire logic VALID_FCS_REQ_IN,
    input wire logic FCS_OK_IN,
    input wire logic EXT_MATCH_IN,
    output logic CHECK_SEQUENCE_SUPPRESS_SIGNAL_OUT,
    output logic STRIP_OUT,
    output logic RING_SAT_OUT,
    output logic SA_IGNORE_OUT,
    output logic CLAIM_REQ_OUT,
    output logic BEACON_REQ_OUT,
    output logic ANY_TYPE_OK_OUT,
    output logic [7:0] TX_FC_OUT,
    output logic CONFIRM_MATCH_OUT,
    output logic END_OPP_OUT,
    output logic [1:0] PRESTAGE_OUT,
    output logic PREEMPT_OUT,
    output logic CHECK_OTHER_OUT,
    output logic [9:0] THRESH_WORDS_OUT
);
    typedef struct packed {
        logic [7:0] ch1;
        logic [7:0] ch0;
    } rcc_cfg_t;

    typedef struct packed {
        logic [1:0] lctl;
        logic [31:0] prdata;
        logic slverr;
        logic check_sequence_suppress_signal;
        logic strip;
        logic ring_sat;
        logic sa_ignore;
        logic claim;
        logic beacon;
        logic any_ok;
        logic [7:0] tx_fc;
        logic match;
        logic end_opp;
        logic [1:0] prestage;
        logic preempt;
        logic check_other;
        logic [9:0] thresh;
    } rcc_run_t;

    typedef struct packed {
        rcc_cfg_t cfg;
        rcc_run_t run;
    } rcc_state_t;

    localparam rcc_run_t RUN_RST = '{
        lctl: rcc_pkg::LCTL_RST,
        prdata: 32'h0000_0000,
        tx_fc: 8'h00,
        prestage: 2'h0,
        thresh: rcc_pkg::THR_NONE,
        default: 1'b0
    };

    rcc_state_t st_reg;
    rcc_state_t st_next;

    logic [1:0] c_check_sequence_suppress_signal, c_strip, c_sat;
    logic [1:0] c_claim, c_beacon, c_any;
    logic [1:0] c_match, c_end, c_pre;
    logic [1:0] c_preempt, c_other;
    logic [7:0] c_txfc [2];
    logic [7:0] cfg_arr [2];

    assign cfg_arr[0] = st_reg.cfg.ch0;
    assign cfg_arr[1] = st_reg.cfg.ch1;

    for (genvar i = 0; i < 2; i++) begin : g_ch
        rcc_chan #(
            .IS_CH1(i == 1)
        ) u_chan (
            .cfg_in(cfg_arr[i]),
            .loaded_in(REQ_LOADED_IN[i]),
            .fetched_in(REQ_FETCHED_IN[i]),
            .immediate_in(IMMEDIATE_IN[i]),
            .repeat_in(REPEAT_IN[i]),
            .fifo_empty_in(FIFO_EMPTY_IN),
            .desc_fc_in(DESC_FC_IN),
            .odu_fc_in(ODU_FC_IN),
            .ret_fc_in(RET_FC_IN),
            .full_conf_in(FULL_CONF_IN),
            .vfcs_req_in(VALID_FCS_REQ_IN),
            .fcs_ok_in(FCS_OK_IN),
            .ext_match_in(EXT_MATCH_IN),
            .check_sequence_suppress_signal_out(c_check_sequence_suppress_signal[i]),
            .strip_out(c_strip[i]),
            .sat_out(c_sat[i]),
            .claim_out(c_claim[i]),
            .beacon_out(c_beacon[i]),
            .any_ok_out(c_any[i]),
            .tx_fc_out(c_txfc[i]),
            .match_out(c_match[i]),
            .end_opp_out(c_end[i]),
            .prestage_out(c_pre[i]),
            .preempt_out(c_preempt[i]),
            .check_other_out(c_other[i])
        );
    end

    logic setup_ph;
    logic wr_acc;
    logic hit_ch0, hit_ch1, hit_lctl, hit_stat;
    logic [1:0] tt;
    logic ext;
    logic [7:0] cfg_act;
    logic a;

    always_comb begin
        st_next = st_reg;
        a = ACTIVE_CH_IN;
        setup_ph = PSEL_IN & ~PENABLE_IN;
        wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN;
        hit_ch0 = PADDR_IN == rcc_pkg::ADDR_CH0;
        hit_ch1 = PADDR_IN == rcc_pkg::ADDR_CH1;
        hit_lctl = PADDR_IN == rcc_pkg::ADDR_LCTL;
        hit_stat = PADDR_IN == rcc_pkg::ADDR_STAT;
        // Writes land at the access edge; no lockout while loaded
        if (wr_acc && hit_ch0) begin
            st_next.cfg.ch0 = PWDATA_IN[7:0]; // [R1]
        end
        if (wr_acc && hit_ch1) begin
            st_next.cfg.ch1 = PWDATA_IN[7:0]; // [R1]
        end
        if (wr_acc && hit_lctl) begin
            st_next.run.lctl = PWDATA_IN[1:0];
        end
        // Read data and error captured in setup, shown in access
        if (setup_ph) begin
            st_next.run.slverr = ~(hit_ch0 | hit_ch1 | hit_lctl | hit_stat);
            st_next.run.prdata = 32'h0000_0000;
            if (!PWRITE_IN) begin
                if (hit_ch0) begin
                    st_next.run.prdata[7:0] = st_reg.cfg.ch0; // [R1]
                end else if (hit_ch1) begin
                    st_next.run.prdata[7:0] = st_reg.cfg.ch1; // [R1]
                end else if (hit_lctl) begin
                    st_next.run.prdata[1:0] = st_reg.run.lctl;
                end else if (hit_stat) begin
                    st_next.run.prdata[9:0] = {
                        REQ_LOADED_IN,
                        st_reg.run.end_opp,
                        st_reg.run.match,
                        st_reg.run.claim,
                        st_reg.run.beacon,
                        st_reg.run.prestage,
                        st_reg.run.check_sequence_suppress_signal,
                        st_reg.run.strip
                    };
                end
            end
        end
        // Ring-facing outputs follow the active channel, except prestage (both channels) and preempt (channel 0)
        st_next.run.check_sequence_suppress_signal = c_check_sequence_suppress_signal[a]; // [R4]
        st_next.run.strip = c_strip[a]; // [R6]
        st_next.run.sa_ignore = c_sat[a]; // [R8]
        if (st_reg.run.lctl[rcc_pkg::BIT_OSEL]) begin
            st_next.run.ring_sat = c_strip[a]; // [R7]
        end else begin
            st_next.run.ring_sat = c_sat[a]; // [R8]
        end
        st_next.run.claim = c_claim[a]; // [R12]
        st_next.run.beacon = c_beacon[a]; // [R12]
        st_next.run.any_ok = c_any[a]; // [R13]
        st_next.run.tx_fc = c_txfc[a]; // [R10]
        st_next.run.match = c_match[a]; // [R11]
        st_next.run.end_opp = c_end[a]; // [R14] [R15]
        st_next.run.prestage = c_pre; // [R16] [R17]
        st_next.run.preempt = c_preempt[0]; // [R20]
        st_next.run.check_other = c_other[a]; // [R18]
        cfg_act = a ? st_reg.cfg.ch1 : st_reg.cfg.ch0;
        tt = cfg_act[rcc_pkg::TT_LSB +: 2];
        ext = st_reg.run.lctl[rcc_pkg::BIT_EXT];
        if (tt == rcc_pkg::TT_LOW) begin
            st_next.run.thresh = ext ? rcc_pkg::THR_512 : rcc_pkg::THR_8; // [R21]
        end else if (tt == rcc_pkg::TT_MID && !ext) begin
            st_next.run.thresh = rcc_pkg::THR_128; // [R21]
        end else begin
            st_next.run.thresh = rcc_pkg::THR_NONE;
        end
    end

    // Config half is never touched by reset
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            st_reg.run <= RUN_RST; // [R3]
        end else begin
            st_reg <= st_next;
        end
    end

    assign PREADY_OUT = PSEL_IN & PENABLE_IN;
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & st_reg.run.slverr;
    assign PRDATA_OUT = st_reg.run.prdata;
    assign CHECK_SEQUENCE_SUPPRESS_SIGNAL_OUT = st_reg.run.check_sequence_suppress_signal;
    assign STRIP_OUT = st_reg.run.strip;
    assign RING_SAT_OUT = st_reg.run.ring_sat;
    assign SA_IGNORE_OUT = st_reg.run.sa_ignore;
    assign CLAIM_REQ_OUT = st_reg.run.claim;
    assign BEACON_REQ_OUT = st_reg.run.beacon;
    assign ANY_TYPE_OK_OUT = st_reg.run.any_ok;
    assign TX_FC_OUT = st_reg.run.tx_fc;
    assign CONFIRM_MATCH_OUT = st_reg.run.match;
    assign END_OPP_OUT = st_reg.run.end_opp;
    assign PRESTAGE_OUT = st_reg.run.prestage;
    assign PREEMPT_OUT = st_reg.run.preempt;
    assign CHECK_OTHER_OUT = st_reg.run.check_other;
    assign THRESH_WORDS_OUT = st_reg.run.thresh;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!NRST_IN);

    sequence s_wr_ch0;
        PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == rcc_pkg::ADDR_CH0;
    endsequence

    sequence s_rd_ch1;
        PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == rcc_pkg::ADDR_CH1;
    endsequence

    property p_wr_ch0;
        s_wr_ch0 |=> st_reg.cfg.ch0 == $past(PWDATA_IN[7:0]);
    endproperty
    a_wr_ch0: assert property (p_wr_ch0) else $error("ch0 write lost"); // [R1]

    property p_rd_ch1;
        s_rd_ch1 ##1 (PSEL_IN && PENABLE_IN) |-> PRDATA_OUT == {24'h00_0000, st_reg.cfg.ch1};
    endproperty
    a_rd_ch1: assert property (p_rd_ch1) else $error("ch1 readback wrong"); // [R1]

    property p_cfg_stable;
        !(PSEL_IN && PENABLE_IN && PWRITE_IN) |=> $stable(st_reg.cfg);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("config changed without write"); // [R3]

    property p_check_sequence_suppress_signal;
        !ACTIVE_CH_IN && REQ_LOADED_IN[0] && st_reg.cfg.ch0[rcc_pkg::BIT_FCS] |=> CHECK_SEQUENCE_SUPPRESS_SIGNAL_OUT;
    endproperty
    a_check_sequence_suppress_signal: assert property (p_check_sequence_suppress_signal) else $error("suppress not held"); // [R4]

    property p_strip;
        ACTIVE_CH_IN && REQ_LOADED_IN[1] && st_reg.cfg.ch1[rcc_pkg::BIT_VST] |=> STRIP_OUT;
    endproperty
    a_strip: assert property (p_strip) else $error("void strip missing"); // [R6]

    property p_ring_sat;
        st_reg.run.lctl[rcc_pkg::BIT_OSEL] ##1 $stable(st_reg.run.lctl) |-> RING_SAT_OUT == STRIP_OUT;
    endproperty
    a_ring_sat: assert property (p_ring_sat) else $error("output select routing wrong"); // [R7]

    property p_sa_ignore;
        REQ_LOADED_IN == 2'h0 |=> !SA_IGNORE_OUT && !CHECK_SEQUENCE_SUPPRESS_SIGNAL_OUT && !STRIP_OUT;
    endproperty
    a_sa_ignore: assert property (p_sa_ignore) else $error("request signal without request"); // [R8]

    property p_tx_fc;
        !ACTIVE_CH_IN && st_reg.cfg.ch0[rcc_pkg::BIT_FCT] |=> TX_FC_OUT == $past(ODU_FC_IN);
    endproperty
    a_tx_fc: assert property (p_tx_fc) else $error("FC not from data unit"); // [R10]

    property p_hold_end;
        REQ_LOADED_IN[ACTIVE_CH_IN] |=> !END_OPP_OUT;
    endproperty
    a_hold_end: assert property (p_hold_end) else $error("opportunity ended mid request"); // [R14]

    property p_prestage1;
        !st_reg.cfg.ch1[rcc_pkg::BIT_HLD] && !IMMEDIATE_IN[1] |=> PRESTAGE_OUT[1];
    endproperty
    a_prestage1: assert property (p_prestage1) else $error("channel 1 not prestaging"); // [R16]

    // Holds under both hold settings, since hold set keeps only the idle term
    property p_end_free;
        !REQ_LOADED_IN[ACTIVE_CH_IN] && !IMMEDIATE_IN[ACTIVE_CH_IN] && FIFO_EMPTY_IN
            && !REQ_FETCHED_IN[ACTIVE_CH_IN] |=> END_OPP_OUT;
    endproperty
    a_end_free: assert property (p_end_free) else $error("opportunity not ended when idle"); // [R15]

    property p_prestage1_hold;
        st_reg.cfg.ch1[rcc_pkg::BIT_HLD] |=> PRESTAGE_OUT[1] == $past(st_reg.cfg.ch1[rcc_pkg::BIT_PRE]);
    endproperty
    a_prestage1_hold: assert property (p_prestage1_hold) else $error("channel 1 prestage ignores bit"); // [R17]

    property p_claim;
        REQ_LOADED_IN[ACTIVE_CH_IN] && DESC_FC_IN == rcc_pkg::FC_CLAIM |=> CLAIM_REQ_OUT && !BEACON_REQ_OUT;
    endproperty
    a_claim: assert property (p_claim) else $error("claim request not decoded"); // [R12]

    property p_check_other;
        REQ_LOADED_IN[ACTIVE_CH_IN] && REPEAT_IN[ACTIVE_CH_IN] && !cfg_act[rcc_pkg::BIT_HLD]
            |=> CHECK_OTHER_OUT;
    endproperty
    a_check_other: assert property (p_check_other) else $error("other channel not checked"); // [R18]

    property p_thresh_low;
        cfg_act[rcc_pkg::TT_LSB +: 2] == rcc_pkg::TT_LOW && !st_reg.run.lctl[rcc_pkg::BIT_EXT]
            |=> THRESH_WORDS_OUT == rcc_pkg::THR_8;
    endproperty
    a_thresh_low: assert property (p_thresh_low) else $error("low threshold wrong"); // [R21]

    property p_fc_strict;
        FULL_CONF_IN && REQ_LOADED_IN[ACTIVE_CH_IN] && !cfg_act[rcc_pkg::BIT_FCT] && RET_FC_IN != DESC_FC_IN
            |=> !CONFIRM_MATCH_OUT;
    endproperty
    a_fc_strict: assert property (p_fc_strict) else $error("match despite FC difference"); // [R11]
endmodule : rcc_top
`default_nettype wire

/* File: pkg/rcc_pkg.sv */
`default_nettype none
package rcc_pkg;
    localparam int ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_CH0 = 12'h110;
    localparam logic [ADDR_W-1:0] IDX_CH1 = 12'h111;
    localparam logic [ADDR_W-1:0] IDX_LCTL = 12'h112;
    localparam logic [ADDR_W-1:0] IDX_STAT = 12'h113;
    localparam logic [ADDR_W-1:0] ADDR_CH0 = IDX_CH0 << 2;
    localparam logic [ADDR_W-1:0] ADDR_CH1 = IDX_CH1 << 2;
    localparam logic [ADDR_W-1:0] ADDR_LCTL = IDX_LCTL << 2;
    localparam logic [ADDR_W-1:0] ADDR_STAT = IDX_STAT << 2;
    // Config register field positions, shared by both channel registers
    localparam int BIT_FCS = 0;
    localparam int BIT_VST = 1;
    localparam int BIT_SAT = 2;
    localparam int BIT_FCT = 3;
    localparam int BIT_HLD = 4;
    localparam int BIT_PRE = 5;
    localparam int TT_LSB = 6;
    // Link control register fields and reset value
    localparam int BIT_OSEL = 0;
    localparam int BIT_EXT = 1;
    localparam logic [1:0] LCTL_RST = 2'h0;
    // Frame control codes
    localparam logic [7:0] FC_CLAIM = 8'hc3;
    localparam logic [7:0] FC_BEACON = 8'hc2;
    localparam logic [7:0] FC_CLR_MASK = 8'hc0;
    // Threshold codes and fill levels in words
    localparam logic [1:0] TT_LOW = 2'h0;
    localparam logic [1:0] TT_MID = 2'h2;
    localparam logic [9:0] THR_8 = 10'h008;
    localparam logic [9:0] THR_512 = 10'h200;
    localparam logic [9:0] THR_128 = 10'h080;
    localparam logic [9:0] THR_NONE = 10'h000;
endpackage : rcc_pkg
`default_nettype wire

/* File: logic/rcc_chan.sv */
`default_nettype none
module rcc_chan #(
    parameter bit IS_CH1 = 1'b0
) (
    input wire logic [7:0] cfg_in,
    input wire logic loaded_in,
    input wire logic fetched_in,
    input wire logic immediate_in,
    input wire logic repeat_in,
    input wire logic fifo_empty_in,
    input wire logic [7:0] desc_fc_in,
    input wire logic [7:0] odu_fc_in,
    input wire logic [7:0] ret_fc_in,
    input wire logic full_conf_in,
    input wire logic vfcs_req_in,
    input wire logic fcs_ok_in,
    input wire logic ext_match_in,
    output logic check_sequence_suppress_signal_out,
    output logic strip_out,
    output logic sat_out,
    output logic claim_out,
    output logic beacon_out,
    output logic any_ok_out,
    output logic [7:0] tx_fc_out,
    output logic match_out,
    output logic end_opp_out,
    output logic prestage_out,
    output logic preempt_out,
    output logic check_other_out
);
    logic check_sequence_disable_bit, void_strip_bit, source_address_transparency, frame_control_transparency_bit, hold_opportunity_bit, pre;
    logic [7:0] mask;
    logic fc_eq;
    always_comb begin
        check_sequence_disable_bit = cfg_in[rcc_pkg::BIT_FCS];
        void_strip_bit = cfg_in[rcc_pkg::BIT_VST];
        source_address_transparency = cfg_in[rcc_pkg::BIT_SAT];
        frame_control_transparency_bit = cfg_in[rcc_pkg::BIT_FCT];
        hold_opportunity_bit = cfg_in[rcc_pkg::BIT_HLD];
        pre = cfg_in[rcc_pkg::BIT_PRE];
        check_sequence_suppress_signal_out = loaded_in & check_sequence_disable_bit; // [R4]
        strip_out = loaded_in & void_strip_bit; // [R6]
        sat_out = loaded_in & source_address_transparency; // [R8]
        // FC comes from the data unit under transparency
        tx_fc_out = frame_control_transparency_bit ? odu_fc_in : desc_fc_in; // [R10]
        mask = frame_control_transparency_bit ? rcc_pkg::FC_CLR_MASK : 8'hff; // [R11]
        fc_eq = ((ret_fc_in ^ desc_fc_in) & mask) == 8'h00; // [R11]
        // CHECK_SEQUENCE_DISABLE_BIT disable bit deliberately plays no part here
        match_out = loaded_in & full_conf_in & fc_eq // [R5]
            & (~vfcs_req_in | fcs_ok_in) // [R5]
            & (~source_address_transparency | ext_match_in); // [R9]
        claim_out = loaded_in & (desc_fc_in == rcc_pkg::FC_CLAIM); // [R12]
        beacon_out = loaded_in & (desc_fc_in == rcc_pkg::FC_BEACON); // [R12]
        any_ok_out = frame_control_transparency_bit & (claim_out | beacon_out); // [R13]
        if (hold_opportunity_bit) begin
            end_opp_out = ~loaded_in; // [R14]
        end else begin
            end_opp_out = ~loaded_in & ~immediate_in // [R15]
                & fifo_empty_in & ~fetched_in; // [R15]
        end
        if (IS_CH1) begin
            prestage_out = hold_opportunity_bit ? pre : ~immediate_in; // [R16] [R17] [R20]
            preempt_out = 1'b0;
        end else begin
            prestage_out = ~immediate_in; // [R20]
            preempt_out = pre; // [R20]
        end
        check_other_out = loaded_in & repeat_in & ~hold_opportunity_bit; // [R18]
    end
endmodule : rcc_chan
`default_nettype wire

/* File: dv/rcc_ring_model.sv */
`default_nettype none
module rcc_ring_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic go_in,
    input wire logic quiet_in,
    input wire logic [31:0] r1_in,
    input wire logic [31:0] r2_in,
    output logic [37:0] ring_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] desc;
    logic [7:0] ret;
    // Random bytes rarely hit the claim and beacon codes
    assign desc = r2_in[2] ? {7'h61, r2_in[3]} : r1_in[7:0];
    // Echo half the time; otherwise one masked or one unmasked bit flipped
    assign ret = desc ^ (r2_in[5:4] == 2'h0 ? 8'h01 : (r2_in[5:4] == 2'h1 ? 8'h40 : 8'h00));
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ring_out <= 38'h00_0000_0000;
        end else if (go_in) begin
            // External match comes from off-block requests drop while reprogrammed
            ring_out <= {r2_in[9:6], ret, r1_in[15:8], desc, r1_in[25:16] & {7'h7f, ~quiet_in, ~quiet_in, 1'b1}};
        end
    end
endmodule : rcc_ring_model
`default_nettype wire

/* File: dv/request_channel_config_tb.sv */
`default_nettype none
module request_channel_config_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, nrst, psel, pen, pwr, go, quiet, rs, any, pready, perr, e;
    logic [11:0] paddr;
    logic [31:0] pwd, prd, r1, r2, q;
    logic [37:0] ring;
    logic [8:0] flg;
    logic [7:0] txfc, cfg0, cfg1;
    logic [9:0] thr;
    logic [1:0] pst, lctl;
    integer seed = 43867;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    rcc_top i_rcc_top (
        .CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwd), .PREADY_OUT(pready), .PRDATA_OUT(prd), .PSLVERR_OUT(perr),
        .ACTIVE_CH_IN(ring[0]), .REQ_LOADED_IN(ring[2:1]), .REQ_FETCHED_IN(ring[4:3]),
        .IMMEDIATE_IN(ring[6:5]), .REPEAT_IN(ring[8:7]), .FIFO_EMPTY_IN(ring[9]),
        .DESC_FC_IN(ring[17:10]), .ODU_FC_IN(ring[25:18]), .RET_FC_IN(ring[33:26]), .FULL_CONF_IN(ring[34]),
        .VALID_FCS_REQ_IN(ring[35]), .FCS_OK_IN(ring[36]), .EXT_MATCH_IN(ring[37]),
        .CHECK_SEQUENCE_SUPPRESS_SIGNAL_OUT(flg[8]), .STRIP_OUT(flg[7]), .RING_SAT_OUT(rs), .SA_IGNORE_OUT(flg[6]),
        .CLAIM_REQ_OUT(flg[5]), .BEACON_REQ_OUT(flg[4]), .ANY_TYPE_OK_OUT(any), .TX_FC_OUT(txfc),
        .CONFIRM_MATCH_OUT(flg[3]), .END_OPP_OUT(flg[2]), .PRESTAGE_OUT(pst), .PREEMPT_OUT(flg[1]),
        .CHECK_OTHER_OUT(flg[0]), .THRESH_WORDS_OUT(thr)
    );
    rcc_ring_model i_rcc_ring_model (
        .clk_in(clk), .nrst_in(nrst), .go_in(go), .quiet_in(quiet), .r1_in(r1), .r2_in(r2), .ring_out(ring)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask : check
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Only the bench timeout ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, q, x);
    endtask : rd
    task automatic vec(input logic qt);
        logic [7:0] c, d;
        logic a, ld, h, fm;
        logic [8:0] xf;
        logic [9:0] xt;
        logic [1:0] xp;
        @(posedge clk);
        go <= 1'b1;
        quiet <= qt;
        r1 <= $random(seed);
        r2 <= $random(seed);
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        a = ring[0];
        c = a ? cfg1 : cfg0;
        ld = a ? ring[2] : ring[1];
        d = ring[17:10];
        h = c[4];
        fm = c[3] ? (((ring[33:26] ^ d) & rcc_pkg::FC_CLR_MASK) == 8'h00) : (ring[33:26] == d);
        xf[8] = ld & c[0];
        xf[7] = ld & c[1];
        xf[6] = ld & c[2];
        xf[5] = ld & (d == rcc_pkg::FC_CLAIM);
        xf[4] = ld & (d == rcc_pkg::FC_BEACON);
        xf[3] = ld & ring[34] & fm & (!ring[35] | ring[36]) & (!c[2] | ring[37]);
        xf[2] = ld ? 1'b0 : (h | (!(a ? ring[6] : ring[5]) & ring[9] & !(a ? ring[4] : ring[3])));
        xf[1] = cfg0[5];
        xf[0] = ld & (a ? ring[8] : ring[7]) & !h;
        case (c[7:6])
            rcc_pkg::TT_LOW: xt = lctl[1] ? rcc_pkg::THR_512 : rcc_pkg::THR_8;
            rcc_pkg::TT_MID: xt = lctl[1] ? rcc_pkg::THR_NONE : rcc_pkg::THR_128;
            default: xt = rcc_pkg::THR_NONE;
        endcase
        check("flags", 32'(flg), 32'(xf));
        check("tx_fc", 32'(txfc), 32'(c[3] ? ring[25:18] : d));
        check("thresh", 32'(thr), 32'(xt));
        xp = {cfg1[4] ? cfg1[5] : !ring[6], !ring[5]};
        check("prestage", 32'(pst), 32'(xp));
        check("ring_sat", 32'(rs), 32'(ld & (lctl[0] ? c[1] : c[2])));
        check("any_type", 32'(any), 32'(ld & (d == rcc_pkg::FC_CLAIM || d == rcc_pkg::FC_BEACON) & c[3]));
        // Ring inputs hold still while the status word is read back
        rd(rcc_pkg::ADDR_STAT, 32'({ring[2:1], xf[2], xf[3], xf[5], xf[4], xp, xf[8], xf[7]}), "status");
    endtask : vec
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h000;
        pwd = 32'h0000_0000;
        go = 1'b0;
        quiet = 1'b1;
        r1 = 32'h0000_0000;
        r2 = 32'h0000_0000;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        cfg0 = 8'($random(seed));
        cfg1 = 8'($random(seed));
        lctl = 2'h3;
        apb(1'b1, rcc_pkg::ADDR_CH0, 32'(cfg0));
        apb(1'b1, rcc_pkg::ADDR_CH1, 32'(cfg1));
        apb(1'b1, rcc_pkg::ADDR_LCTL, 32'(lctl));
        rd(rcc_pkg::ADDR_CH0, 32'(cfg0), "ch0");
        rd(rcc_pkg::ADDR_CH1, 32'(cfg1), "ch1");
        rd(rcc_pkg::ADDR_LCTL, 32'(lctl), "lctl");
        apb(1'b1, 12'h450, 32'hffff_ffff);
        check("wr_err", 32'(e), 32'h0000_0001);
        rd(12'h450, 32'h0000_0000, "unmapped");
        check("rd_err", 32'(e), 32'h0000_0001);
        $display("Test registers done");
        // Mid-run reset: config must survive, link control clears
        @(posedge clk);
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        lctl = 2'h0;
        rd(rcc_pkg::ADDR_CH0, 32'(cfg0), "ch0_rst");
        rd(rcc_pkg::ADDR_CH1, 32'(cfg1), "ch1_rst");
        rd(rcc_pkg::ADDR_LCTL, 32'(lctl), "lctl_rst");
        $display("Test reset done");
        for (int b = 0; b < 8; b++) begin
            // Requests idle before software touches the config
            vec(1'b1);
            cfg0 = 8'($random(seed));
            cfg1 = 8'($random(seed));
            if (b[0]) begin
                cfg0[rcc_pkg::BIT_HLD] = 1'b1;
            end
            lctl = 2'(b);
            apb(1'b1, rcc_pkg::ADDR_CH0, 32'(cfg0));
            apb(1'b1, rcc_pkg::ADDR_CH1, 32'(cfg1));
            apb(1'b1, rcc_pkg::ADDR_LCTL, 32'(lctl));
            repeat (30) vec(1'b0);
        end
        $display("Test ring done");
        give_verdict();
    end
endmodule : request_channel_config_tb
`default_nettype wire
